// ### ddci_params.svh
`ifndef DDCI_PARAMS_SVH
`define DDCI_PARAMS_SVH

// ****************************************
// Geometry of one rank and number of ranks
// ****************************************
`define DDCI_ROW_W      16
`define DDCI_COL_W      10
`define DDCI_BANK_W     3
`define DDCI_BANKS      8
`define DDCI_RANKS      2
`define DDCI_MR_COUNT   4

// ****************************************
// Address bit positions
// ****************************************
`define DDCI_AP_BIT     10
`define DDCI_BC_BIT     12
`define DDCI_MR0_BL_LO  0
`define DDCI_MR1_RTT_A  2
`define DDCI_MR1_RTT_B  6
`define DDCI_MR1_RTT_C  9
`define DDCI_MR2_WR_LO  9

// ****************************************
// Field encodings and reset values
// ****************************************
`define DDCI_BL_OTF     2'h1
`define DDCI_BL_BC4     2'h2
`define DDCI_MR_RST     16'h0000
`define DDCI_OPEN_RST   8'h00
`define DDCI_CA_IDLE    30'h0F800000

// ****************************************
// Latencies and refresh timing
// ****************************************
`define DDCI_CL_1600    11
`define DDCI_CL_1866    13
`define DDCI_CL_MAX     16
`define DDCI_BURST_BL8  3'h4
`define DDCI_BURST_BC4  3'h2
`define DDCI_CLK_PS     64'd5000
`define DDCI_REF_CMDS   64'd8192
`define DDCI_REF_NORM_MS 64'd64
`define DDCI_REF_HOT_MS  64'd32
`define DDCI_REFI_NORM_CYC \
  ((`DDCI_REF_NORM_MS * 64'd1000000000) / (`DDCI_REF_CMDS * `DDCI_CLK_PS))
`define DDCI_REFI_HOT_CYC \
  ((`DDCI_REF_HOT_MS * 64'd1000000000) / (`DDCI_REF_CMDS * `DDCI_CLK_PS))

`endif

// ### ddci_pkg.sv
package ddci_pkg;

  // Decoded command of one rank
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ
  } ddci_cmd_kind_t;

  // Power state of one rank
  typedef enum logic [1:0] {
    PS_ACTIVE, PS_PRE_PD, PS_ACT_PD, PS_SELF_REF
  } ddci_pwr_t;

  // Command, address and control pins as sampled
  typedef struct packed {
    logic [1:0]  cke;
    logic [1:0]  cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [15:0] addr;
    logic [2:0]  ba;
    logic [1:0]  odt;
    logic        ldm;
    logic        udm;
  } ddci_ca_t;

  // Command handed to the rank core
  typedef struct packed {
    logic           valid;
    ddci_cmd_kind_t kind;
    logic [2:0]     bank;
    logic [15:0]    row;
    logic [9:0]     col;
    logic           auto_pre;
    logic           bc4;
    logic [1:0]     mr_sel;
    logic [15:0]    opcode;
  } ddci_cmd_t;

endpackage

// ### ddci_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddci_params.svh"

// Operation
// [RULE1] ACTIVATE takes row; READ/WRITE column, A10 autoprecharge
// [RULE2] PRECHARGE closes one bank, A10 high all
// [RULE3] LOAD MODE writes address lines as op-code
// [RULE4] Burst chop on the fly samples A12
// [RULE5] Bank inputs pick target bank
// [RULE6] Bank inputs pick mode register MR0-MR3
// [RULE7] Inputs captured on rising clock edge
// [RULE8] Read strobe timed from clock edges
// [RULE9] Per-rank clock enable gates internal circuitry
// [RULE10] CKE low enters precharge, active PD, self refresh
// [RULE11] Self-refresh exit needs no gated clock
// [RULE12] Power-down keeps clock, CKE, reset, ODT receivers
// [RULE13] Self refresh keeps only CKE and reset
// [RULE14] Chip select high masks all commands
// [RULE15] Controller selects rank by its chip select
// [RULE16] Command decoded from RAS, CAS, WE, CS
// [RULE17] Lower mask high blocks lower-byte write beat
// [RULE18] ODT switches termination on data pins
// [RULE19] ODT ignored when termination disabled by mode
// [RULE20] Controller refreshes 8192 per 64ms or 32ms
// [RULE21] 16-bit row, 8 banks, 10-bit column, two ranks
// [RULE22] Read latency 11 or 13 clocks per grade
// [RULE23] Reset pin active low and asynchronous
// [RULE24] Read data leaves edge-aligned with strobe
// [RULE25] Ranks keep separate state, ignore each other
module ddci_top #(
  parameter int unsigned CAS_LAT = `DDCI_CL_1600, // RULE22
  parameter int unsigned RANKS   = `DDCI_RANKS,
  parameter int unsigned ROW_W   = `DDCI_ROW_W,
  parameter int unsigned COL_W   = `DDCI_COL_W
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire logic                      dram_reset_n_i,
  input  wire ddci_pkg::ddci_ca_t        ca_i,
  input  wire logic                      wr_beat_i,
  output var  ddci_pkg::ddci_cmd_t [1:0] cmd_o,
  output var  ddci_pkg::ddci_pwr_t [1:0] pwr_state_o,
  output logic [1:0][7:0]                bank_open_o,
  output logic [1:0][3:0][15:0]          mode_reg_o,
  output logic [1:0]                     term_en_o,
  output logic [1:0]                     cmd_rx_en_o,
  output logic [1:0]                     clk_rx_en_o,
  output logic                           rd_strobe_oe_o,
  output logic [1:0]                     wr_lane_we_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // The datapath widths are fixed by the pin struct
  if (RANKS != 2 || ROW_W != 16 || COL_W != 10) // RULE21
  begin : g_geom_chk
    $error("ddci_top: unsupported geometry");
  end
  if (CAS_LAT < 1 || CAS_LAT > `DDCI_CL_MAX)
  begin : g_cl_chk
    $error("ddci_top: CAS_LAT out of range");
  end

  localparam int RD_LAT = CAS_LAT;

  // ****************************************
  // Helper functions
  // ****************************************
  // Command from the three strobes, chip select already checked
  function automatic ddci_pkg::ddci_cmd_kind_t cmd_dec(
    input logic [2:0] rcw
  );
    ddci_pkg::ddci_cmd_kind_t k;
    k = ddci_pkg::CMD_NOP;
    unique case (rcw) // RULE16
      3'h0: k = ddci_pkg::CMD_MRS;
      3'h1: k = ddci_pkg::CMD_REF;
      3'h2: k = ddci_pkg::CMD_PRE;
      3'h3: k = ddci_pkg::CMD_ACT;
      3'h4: k = ddci_pkg::CMD_WR;
      3'h5: k = ddci_pkg::CMD_RD;
      3'h6: k = ddci_pkg::CMD_ZQ;
      3'h7: k = ddci_pkg::CMD_NOP;
    endcase
    return k;
  endfunction

  // Chopped burst from MR0 mode and the A12 sample
  function automatic logic chop_of(input logic [15:0] mr0,
                                   input logic        a12);
    logic [1:0] bl;
    bl = mr0[`DDCI_MR0_BL_LO +: 2];
    if (bl == `DDCI_BL_OTF)
      return ~a12; // RULE4
    return (bl == `DDCI_BL_BC4);
  endfunction

  // Termination disabled when every nominal and write field is off
  function automatic logic odt_off(input logic [15:0] mr1,
                                   input logic [15:0] mr2);
    return ~(mr1[`DDCI_MR1_RTT_A] | mr1[`DDCI_MR1_RTT_B] |
             mr1[`DDCI_MR1_RTT_C] | (|mr2[`DDCI_MR2_WR_LO +: 2]));
  endfunction

  // ****************************************
  // Reset and pin capture
  // ****************************************
  logic [1:0]         arst_pipe_reg; // Release stretcher for reset pin
  logic               arst_n;        // Internal reset, low asserted
  ddci_pkg::ddci_ca_t ca_meta_reg;   // First capture stage
  ddci_pkg::ddci_ca_t ca_reg;        // Registered pins

  // Reset pin asserts at once; release goes through two flops so
  // no state leaves reset on a partial edge
  always_ff @(posedge mclk_i or negedge dram_reset_n_i)
  begin
    if (!dram_reset_n_i)
      arst_pipe_reg <= 2'h0; // RULE23
    else
      arst_pipe_reg <= {arst_pipe_reg[0], 1'b1};
  end

  assign arst_n = arst_pipe_reg[1];

  // All command and address pins sample on the rising edge
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ca_meta_reg <= `DDCI_CA_IDLE;
      ca_reg      <= `DDCI_CA_IDLE;
    end
    else if (rst_i)
    begin
      ca_meta_reg <= `DDCI_CA_IDLE;
      ca_reg      <= `DDCI_CA_IDLE;
    end
    else
    begin
      ca_meta_reg <= ca_i;        // RULE7
      ca_reg      <= ca_meta_reg;
    end
  end

  // ****************************************
  // Command decode per rank
  // ****************************************
  ddci_pkg::ddci_pwr_t      [1:0]      pwr_reg;       // Power state
  logic                     [1:0][7:0] bank_open_reg; // Open rows
  logic [1:0][7:0][15:0]               row_reg;       // Open row number
  logic [1:0][3:0][15:0]               mr_reg;        // Mode registers
  ddci_pkg::ddci_cmd_kind_t [1:0]      kind_w;        // Decoded command
  logic                     [1:0]      sr_entry_w;    // Self-refresh entry

  // Decoder listens only to a selected, active rank; with its clock enable low it only looks for self-refresh entry
  always_comb
  begin
    for (int r = 0; r < 2; r++)
    begin
      kind_w[r]     = ddci_pkg::CMD_NOP;
      sr_entry_w[r] = 1'b0;
      if (!ca_reg.cs_n[r] && pwr_reg[r] == ddci_pkg::PS_ACTIVE) // RULE14
      begin
        if (ca_reg.cke[r]) // RULE9
          kind_w[r] = cmd_dec({ca_reg.ras_n, ca_reg.cas_n, ca_reg.we_n});
        else
          sr_entry_w[r] = (cmd_dec({ca_reg.ras_n, ca_reg.cas_n,
                                    ca_reg.we_n}) == ddci_pkg::CMD_REF) &&
                          (bank_open_reg[r] == `DDCI_OPEN_RST);
      end
    end
  end

  // ****************************************
  // Power state
  // ****************************************
  // Exit from self refresh watches the captured enable on the free
  // running core clock, so no edge of the stopped memory clock is needed
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_reg[0] <= ddci_pkg::PS_PRE_PD;
      pwr_reg[1] <= ddci_pkg::PS_PRE_PD;
    end
    else if (rst_i)
    begin
      pwr_reg[0] <= ddci_pkg::PS_PRE_PD;
      pwr_reg[1] <= ddci_pkg::PS_PRE_PD;
    end
    else
      for (int r = 0; r < 2; r++)
      begin
        unique case (pwr_reg[r])
          ddci_pkg::PS_ACTIVE:
            if (sr_entry_w[r])
              pwr_reg[r] <= ddci_pkg::PS_SELF_REF; // RULE10
            else if (!ca_reg.cke[r] && |bank_open_reg[r])
              pwr_reg[r] <= ddci_pkg::PS_ACT_PD;   // RULE10
            else if (!ca_reg.cke[r])
              pwr_reg[r] <= ddci_pkg::PS_PRE_PD;   // RULE10
          ddci_pkg::PS_PRE_PD, ddci_pkg::PS_ACT_PD:
            if (ca_reg.cke[r])
              pwr_reg[r] <= ddci_pkg::PS_ACTIVE;   // RULE11
          ddci_pkg::PS_SELF_REF:
            if (ca_reg.cke[r])
              pwr_reg[r] <= ddci_pkg::PS_ACTIVE;   // RULE11
        endcase
      end
  end

  // Receiver enables follow the power state
  always_comb
  begin
    for (int r = 0; r < 2; r++)
    begin
      cmd_rx_en_o[r] = (pwr_reg[r] == ddci_pkg::PS_ACTIVE);    // RULE12
      clk_rx_en_o[r] = (pwr_reg[r] != ddci_pkg::PS_SELF_REF);  // RULE13
    end
  end

  // ****************************************
  // Bank state
  // ****************************************
  // Each rank only reacts to its own decoded command
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
      bank_open_reg <= '0;
    else if (rst_i)
      bank_open_reg <= '0;
    else
      for (int r = 0; r < 2; r++) // RULE25
      begin
        if (kind_w[r] == ddci_pkg::CMD_ACT)
        begin
          bank_open_reg[r][ca_reg.ba]  <= 1'b1;      // RULE5
        end
        else if (kind_w[r] == ddci_pkg::CMD_PRE)
        begin
          if (ca_reg.addr[`DDCI_AP_BIT])
            bank_open_reg[r] <= `DDCI_OPEN_RST;      // RULE2
          else
            bank_open_reg[r][ca_reg.ba] <= 1'b0;     // RULE2
        end
        else if ((kind_w[r] == ddci_pkg::CMD_RD ||
                  kind_w[r] == ddci_pkg::CMD_WR) &&
                 ca_reg.addr[`DDCI_AP_BIT])
          bank_open_reg[r][ca_reg.ba] <= 1'b0;       // RULE1
      end
  end

  // Row number of each bank; reset so reads of idle banks show no unknowns
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
      row_reg <= '0;
    else if (rst_i)
      row_reg <= '0;
    else
      for (int r = 0; r < 2; r++)
        if (kind_w[r] == ddci_pkg::CMD_ACT)
          row_reg[r][ca_reg.ba] <= ca_reg.addr; // RULE1
  end

  // ****************************************
  // Mode registers
  // ****************************************
  // Writes with the top bank bit set target reserved space; dropped
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
      mr_reg <= '0;
    else if (rst_i)
      mr_reg <= '0;
    else
      for (int r = 0; r < 2; r++)
        if (kind_w[r] == ddci_pkg::CMD_MRS && !ca_reg.ba[2])
          mr_reg[r][ca_reg.ba[1:0]] <= ca_reg.addr; // RULE3 RULE6
  end

  // ****************************************
  // Command output
  // ****************************************
  // Read and write carry the open row of their bank for convenience
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
      cmd_o <= '0;
    else if (rst_i)
      cmd_o <= '0;
    else
      for (int r = 0; r < 2; r++)
      begin
        cmd_o[r].valid    <= (kind_w[r] != ddci_pkg::CMD_NOP); // RULE14
        cmd_o[r].kind     <= kind_w[r];
        cmd_o[r].bank     <= ca_reg.ba;                        // RULE5
        cmd_o[r].row      <= (kind_w[r] == ddci_pkg::CMD_ACT) ?
                             ca_reg.addr : row_reg[r][ca_reg.ba];
        cmd_o[r].col      <= ca_reg.addr[9:0];                 // RULE1
        cmd_o[r].auto_pre <= ca_reg.addr[`DDCI_AP_BIT];
        cmd_o[r].bc4      <= chop_of(mr_reg[r][0],
                                     ca_reg.addr[`DDCI_BC_BIT]); // RULE4
        cmd_o[r].mr_sel   <= ca_reg.ba[1:0];                   // RULE6
        cmd_o[r].opcode   <= ca_reg.addr;                      // RULE3
      end
  end

  // ****************************************
  // Termination control
  // ****************************************
  // Termination is held off in self refresh, where ODT is not received
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
      term_en_o <= 2'h0;
    else if (rst_i)
      term_en_o <= 2'h0;
    else
      for (int r = 0; r < 2; r++)
        term_en_o[r] <= ca_reg.odt[r] &&                        // RULE18
                        !odt_off(mr_reg[r][1], mr_reg[r][2]) &&  // RULE19
                        pwr_reg[r] != ddci_pkg::PS_SELF_REF;
  end

  // ****************************************
  // Read strobe timing
  // ****************************************
  logic                   rd_start_w;    // A read taken this cycle
  logic                   rd_chop_w;     // Its burst is chopped
  logic [`DDCI_CL_MAX-1:0] rd_dly_reg;   // Read latency delay line
  logic [`DDCI_CL_MAX-1:0] chop_dly_reg; // Chop flag alongside
  logic [2:0]             rd_left_reg;   // Strobe clocks left

  // Both ranks share the data pins; the controller never overlaps reads
  assign rd_start_w = (kind_w[0] == ddci_pkg::CMD_RD) ||
                      (kind_w[1] == ddci_pkg::CMD_RD);
  assign rd_chop_w  = (kind_w[0] == ddci_pkg::CMD_RD) ?
                      chop_of(mr_reg[0][0], ca_reg.addr[`DDCI_BC_BIT]) :
                      chop_of(mr_reg[1][0], ca_reg.addr[`DDCI_BC_BIT]);

  // A delay line, not a counter, so back-to-back reads both survive
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_dly_reg   <= '0;
      chop_dly_reg <= '0;
    end
    else if (rst_i)
    begin
      rd_dly_reg   <= '0;
      chop_dly_reg <= '0;
    end
    else
    begin
      rd_dly_reg   <= {rd_dly_reg[`DDCI_CL_MAX-2:0], rd_start_w}; // RULE8
      chop_dly_reg <= {chop_dly_reg[`DDCI_CL_MAX-2:0], rd_chop_w};
    end
  end

  // Strobe launches on the clock edge together with the data
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
      rd_left_reg <= 3'h0;
    else if (rst_i)
      rd_left_reg <= 3'h0;
    else if (CAS_LAT == 1 && rd_start_w)
      rd_left_reg <= rd_chop_w ? `DDCI_BURST_BC4 : `DDCI_BURST_BL8;
    else if (CAS_LAT > 1 && rd_dly_reg[CAS_LAT-2])
      rd_left_reg <= chop_dly_reg[CAS_LAT-2] ?
                     `DDCI_BURST_BC4 : `DDCI_BURST_BL8; // RULE24
    else if (rd_left_reg != 3'h0)
      rd_left_reg <= rd_left_reg - 3'h1;
  end

  assign rd_strobe_oe_o = (rd_left_reg != 3'h0); // RULE8 RULE24

  // ****************************************
  // Write byte mask
  // ****************************************
  // Beats arrive already aligned to the captured mask pins
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
      wr_lane_we_o <= 2'h0;
    else if (rst_i)
      wr_lane_we_o <= 2'h0;
    else
      wr_lane_we_o <= {wr_beat_i && !ca_reg.udm,
                       wr_beat_i && !ca_reg.ldm}; // RULE17
  end

  assign pwr_state_o = pwr_reg;
  assign bank_open_o = bank_open_reg;
  assign mode_reg_o  = mr_reg;

  // ****************************************
  // Assertions
  // ****************************************
  a_act_opens: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE1
    kind_w[0] == ddci_pkg::CMD_ACT |=> bank_open_reg[0][cmd_o[0].bank])
    else $error("activate did not open bank");
  a_pre_all: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE2
    kind_w[0] == ddci_pkg::CMD_PRE && ca_reg.addr[`DDCI_AP_BIT] |=> bank_open_reg[0] == 8'h00)
    else $error("precharge all left a bank open");
  a_mrs_load: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE3
    kind_w[0] == ddci_pkg::CMD_MRS && !ca_reg.ba[2] |=> mr_reg[0][cmd_o[0].mr_sel] == cmd_o[0].opcode)
    else $error("mode register not loaded");
  a_chop_otf: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE4
    kind_w[0] == ddci_pkg::CMD_RD && mr_reg[0][0][1:0] == `DDCI_BL_OTF && !ca_reg.addr[`DDCI_BC_BIT]
    |=> cmd_o[0].bc4)
    else $error("A12 low did not chop");
  a_cs_masks: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE14
    ca_reg.cs_n[0] |=> !cmd_o[0].valid)
    else $error("command taken with chip select high");
  a_sref_entry: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE13
    sr_entry_w[0] |=> pwr_reg[0] == ddci_pkg::PS_SELF_REF && !clk_rx_en_o[0])
    else $error("self refresh not entered");
  a_apd_entry: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE10
    pwr_reg[0] == ddci_pkg::PS_ACTIVE && !ca_reg.cke[0] && |bank_open_reg[0] && !sr_entry_w[0]
    |=> pwr_reg[0] == ddci_pkg::PS_ACT_PD && !cmd_rx_en_o[0])
    else $error("active power-down not entered");
  a_sref_exit: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE11
    pwr_reg[0] == ddci_pkg::PS_SELF_REF && ca_reg.cke[0] |=> pwr_reg[0] == ddci_pkg::PS_ACTIVE)
    else $error("self refresh exit missed");
  a_wr_mask: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE17
    wr_beat_i && ca_reg.ldm |=> !wr_lane_we_o[0])
    else $error("masked lower byte written");
  a_odt_ignored: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE19
    odt_off(mr_reg[0][1], mr_reg[0][2]) |=> !term_en_o[0])
    else $error("termination on while disabled");
  a_rd_strobe: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE8
    rd_start_w |-> ##RD_LAT rd_strobe_oe_o)
    else $error("read strobe not at latency");
  a_rank_isolate: assert property (@(posedge mclk_i) disable iff (!arst_n || rst_i) // RULE25
    ca_reg.cs_n[1] |=> $stable(bank_open_reg[1]))
    else $error("unselected rank changed banks");

endmodule

`default_nettype wire

// ### ddci_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddci_params.svh"
// ****************************************
// Controller model on the command pins
// ****************************************
module ddci_ctrl_model (
  input  wire logic               mclk_i,
  output var  ddci_pkg::ddci_ca_t ca_o
);
  // Power-up: ranks off and deselected
  initial ca_o = `DDCI_CA_IDLE;

  // One command slot, pins move only after a falling edge
  task automatic issue(input logic [1:0] cke, input logic [1:0] cs_n, input logic [2:0] rcw,
                       input logic [15:0] a, input logic [2:0] b);
    @(negedge mclk_i);
    ca_o.cke                             = cke;
    ca_o.cs_n                            = cs_n;
    {ca_o.ras_n, ca_o.cas_n, ca_o.we_n} = rcw;
    ca_o.addr                            = a;
    ca_o.ba                              = b;
    @(negedge mclk_i);
    // Released lines flip so a stale value never reads as good
    ca_o.cs_n                            = 2'h3;
    {ca_o.ras_n, ca_o.cas_n, ca_o.we_n} = 3'h7;
    ca_o.addr                            = ~a;
    ca_o.ba                              = ~b;
  endtask

  // Level pins: clock enable, termination, masks
  task automatic set_ctl(input logic [1:0] cke, input logic [1:0] odt, input logic [1:0] dm);
    @(negedge mclk_i);
    ca_o.cke              = cke;
    ca_o.odt              = odt;
    {ca_o.ldm, ca_o.udm} = dm;
  endtask
endmodule
`default_nettype wire

// ### ddci_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddci_params.svh"
// ****************************************
// Self-checking bench
// ****************************************
module ddci_top_test;
  localparam int unsigned CL = `DDCI_CL_1866; // Slower default would hide a fixed latency
  logic                      mclk_i     = 1'b0;     // Core clock
  logic                      rst_i      = 1'b1;     // Sync reset
  logic                      dram_rst_n = 1'b0;     // Device reset pin
  logic                      beat       = 1'b0;     // Write beat
  ddci_pkg::ddci_ca_t        ca;                    // Pins from controller
  ddci_pkg::ddci_cmd_t [1:0] cmd;                   // Decoded commands
  ddci_pkg::ddci_pwr_t [1:0] pwr;                   // Power states
  logic [1:0][7:0]           bopen;                 // Open rows
  logic [1:0][3:0][15:0]     mr;                    // Mode registers
  logic [1:0]                term, crx, krx, lane;  // Level outputs
  logic                      strobe;                // Read drive window
  logic [15:0]               rnd        = 16'h0027; // Fixed seed
  logic [15:0]               a;                     // Address sent
  logic [15:0]               op [4];                // Mode values sent
  int                        err_count  = 0;
  int                        comparisons = 0;
  int                        n, first, r;
  logic [7:0]                open0      = 8'hDB;    // Rank 0 open rows expected

  // Clock
  always #2.5 mclk_i = ~mclk_i;

  ddci_top #(.CAS_LAT(CL)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .dram_reset_n_i(dram_rst_n), .ca_i(ca), .wr_beat_i(beat),
    .cmd_o(cmd), .pwr_state_o(pwr), .bank_open_o(bopen), .mode_reg_o(mr), .term_en_o(term),
    .cmd_rx_en_o(crx), .clk_rx_en_o(krx), .rd_strobe_oe_o(strobe), .wr_lane_we_o(lane)
  );
  ddci_ctrl_model ctl_u (.mclk_i(mclk_i), .ca_o(ca));

  // Next random value
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Chop expected from burst field and chop pin
  function automatic logic exp_bc4(input logic [1:0] bl, input logic a12);
    return (bl == `DDCI_BL_BC4) || (bl == `DDCI_BL_OTF && !a12);
  endfunction

  // Compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Issue, then stand in the cycle after the answer edge
  task automatic send(input logic [1:0] cke, input logic [1:0] cs_n, input logic [2:0] rcw,
                      input logic [15:0] a, input logic [2:0] b);
    ctl_u.issue(cke, cs_n, rcw, a, b);
    repeat (2) @(negedge mclk_i);
  endtask

  // Level change, then let capture and state settle
  task automatic lvl(input logic [1:0] cke, input logic [1:0] odt);
    ctl_u.set_ctl(cke, odt, 2'h0);
    repeat (5) @(negedge mclk_i);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge mclk_i);
    chk(pwr, 4'h5);
    chk(krx, 2'h3);
    rst_i = 1'b0;
    dram_rst_n = 1'b1;
    lvl(2'h3, 2'h0);
    chk(pwr, 4'h0);
    // Every mode register through its bank code
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      op[i] = rnd;
      if (i == 0) op[i][1:0] = `DDCI_BL_OTF;
      if (i == 1) op[i][2] = 1'b1;
      send(2'h3, 2'h2, 3'h0, op[i], i[2:0]);
      chk(cmd[0].kind, ddci_pkg::CMD_MRS);
      chk(mr[0][i], op[i]);
      chk(mr[1][i], 16'h0000);
    end
    // A row in every bank, the last at the top row
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      a = (k == 7) ? 16'hFFFF : rnd;
      send(2'h3, 2'h2, 3'h3, a, k[2:0]);
      chk(cmd[0].row, a);
      chk(cmd[0].bank, k);
    end
    chk(bopen, 16'h00FF);
    // Reads with chop pin low then high, window timed and counted
    for (int j = 0; j < 2; j++)
    begin
      rnd = lfsr(rnd);
      a = {3'h0, j[0], 2'h0, rnd[9:0]};
      send(2'h3, 2'h2, 3'h5, a, 3'h3);
      chk(cmd[0].col, a[9:0]);
      chk(cmd[0].bc4, exp_bc4(op[0][1:0], a[12]));
      n = 0;
      first = 0;
      for (int t = 1; t < CL + 8; t++)
      begin
        @(negedge mclk_i);
        if (strobe === 1'b1 && first == 0) first = t;
        if (strobe === 1'b1) n++;
      end
      chk(first, CL - 1);
      chk(n, a[12] ? 4 : 2);
    end
    // Write with auto-precharge, then single-bank and deselected precharges
    send(2'h3, 2'h2, 3'h4, 16'h0455, 3'h5);
    chk(cmd[0].auto_pre, 1'b1);
    send(2'h3, 2'h2, 3'h2, 16'hFBFF, 3'h2);
    chk(bopen[0], 8'hDB);
    send(2'h3, 2'h3, 3'h2, 16'h0400, 3'h0);
    chk(cmd[0].valid, 1'b0);
    send(2'h3, 2'h1, 3'h2, 16'h0400, 3'h0);
    chk(cmd[1].valid, 1'b1);
    chk(bopen[0], 8'hDB);
    // Random activates over both ranks
    repeat (20)
    begin
      rnd = lfsr(rnd);
      r = rnd[15];
      send(2'h3, r ? 2'h1 : 2'h2, 3'h3, rnd, rnd[2:0]);
      chk(cmd[r].row, rnd);
      chk(bopen[r][rnd[2:0]], 1'b1);
      if (r == 0) open0[rnd[2:0]] = 1'b1;
    end
    // Every mask pair against one beat
    for (int m = 0; m < 4; m++)
    begin
      ctl_u.set_ctl(2'h3, 2'h0, m[1:0]);
      repeat (2) @(negedge mclk_i);
      beat = 1'b1;
      @(negedge mclk_i);
      beat = 1'b0;
      chk(lane, {~m[0], ~m[1]});
    end
    // Termination only where a mode register allows it
    lvl(2'h3, 2'h3);
    chk(term, 2'h1);
    lvl(2'h3, 2'h0);
    chk(term, 2'h0);
    // Power-down with rows open; a precharge there is refused
    lvl(2'h2, 2'h0);
    chk(pwr, {ddci_pkg::PS_ACTIVE, ddci_pkg::PS_ACT_PD});
    chk({crx, krx}, 4'hB);
    send(2'h2, 2'h2, 3'h2, 16'h0400, 3'h0);
    chk(bopen[0], open0);
    lvl(2'h3, 2'h0);
    chk(pwr[0], ddci_pkg::PS_ACTIVE);
    send(2'h3, 2'h2, 3'h2, 16'h0400, 3'h0);
    chk(bopen[0], 8'h00);
    lvl(2'h2, 2'h0);
    chk(pwr[0], ddci_pkg::PS_PRE_PD);
    lvl(2'h3, 2'h0);
    // Refresh as clock enable drops: self refresh
    send(2'h2, 2'h2, 3'h1, 16'h0000, 3'h0);
    chk(pwr[0], ddci_pkg::PS_SELF_REF);
    chk({crx[0], krx[0]}, 2'h0);
    lvl(2'h3, 2'h0);
    chk(pwr[0], ddci_pkg::PS_ACTIVE);
    // Periodic refresh and calibration while running
    send(2'h3, 2'h2, 3'h1, 16'h0000, 3'h0);
    chk(cmd[0].kind, ddci_pkg::CMD_REF);
    send(2'h3, 2'h2, 3'h6, 16'h0400, 3'h0);
    chk(cmd[0].kind, ddci_pkg::CMD_ZQ);
    // Device reset pin drops between clock edges
    @(negedge mclk_i);
    dram_rst_n = 1'b0;
    #1;
    chk(pwr[0], ddci_pkg::PS_PRE_PD);
    chk(mr[0][1], 16'h0000);
    finish_test();
  end

  // Hang guard, far beyond the sequence length
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
